//--- logic/transaction_control_service.sv
// Notes on behaviour
// - commands carry count in word 0, router 0x0400 in word 1, sub in word 2
// - end batch drops undelivered volume and ends the batch
// - end batch closes the valve unless already commanded closed
// - end transaction ends it, removes authorization, marks it done
// - remote start acts exactly like the local start key
// - remote stop shuts valve and pump whether or not product flows
// - a stopped batch resumes only by start key or remote start
// - subs up to 7 answer: count 6, router 0x8400, return code, echo
// - sub 8 in a four-word packet requests the status flag answer
// - status answer: count 38, router 0x8300, return code, echo, flags
// - flags read zero false, nonzero true; words 4 to 8 listed
// - words 9 to 13: delays, flowing, injectors, proving
// - words 14 to 19: alarm, program states, power fail, print queued
// - word 20 arm position; words 21 to 23 standby, storage, lock
// - sub 9 clears transaction done and batch done
// - sub 10 clears batch done only
// - sub 11 clears power fail occurred
// - clear subs answer six words with router 0x8400 and echo
// - sub 12 clears program value changed, six-word answer
`include "tc_consts.svh"

module transaction_control_service
  import tc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [11:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire dev_status_s dev_i,
  output dev_ctl_s ctl_o
);

  dev_status_s s1_reg, s2_reg, s3_reg, dev_reg, prev_reg, rise;
  logic ack_reg;
  logic [31:0] dat_reg;
  logic [15:0] cmd_mem [0:3];
  logic [15:0] resp_mem [0:`TC_RSP_WORDS-1];
  logic [15:0] rsp_w [0:`TC_RSP_WORDS-1];
  logic [15:0] rc_reg;
  dev_ctl_s ctl_reg;
  logic authorized_reg, paused_reg, txn_active_reg;
  logic batch_done_reg, txn_done_reg, pfail_reg, pchg_reg;
  logic req, acc, exec_go, cmd_ok, start_evt, halt;
  logic do_eb, do_et, do_start, do_stop, do_stat;
  logic do_clr_both, do_clr_batch, do_clr_pf, do_clr_pg;
  logic [15:0] sub, rc_w;
  logic [11:0] roff;
  logic [31:0] rdata;
  logic [19:0] flags_w;

  // three-stage pin capture; a bit moves only once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      dev_reg <= '0;
      prev_reg <= '0;
    end else begin
      s1_reg <= dev_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      dev_reg <= (s2_reg & s3_reg) | (dev_reg & (s2_reg ^ s3_reg));
      prev_reg <= dev_reg;
    end
  end
  assign rise = dev_reg & ~prev_reg;

  // wishbone: ack one cycle after the request, writes land on the ack edge
  assign req = cyc_i & stb_i;
  assign acc = req & ack_reg;
  assign exec_go = acc & we_i & sel_i[0] & (adr_i == `TC_ADR_EXEC);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= '0;
    end else begin
      ack_reg <= req & ~ack_reg;
      if (req & ~ack_reg) begin
        dat_reg <= rdata;
      end
    end
  end
  assign ack_o = ack_reg;
  assign dat_o = dat_reg;

  assign roff = adr_i - `TC_ADR_RSP;
  always_comb begin
    rdata = '0;
    if (adr_i < `TC_ADR_CMD_END) begin
      rdata = {16'h0000, cmd_mem[adr_i[3:2]]};
    end else if (adr_i == `TC_ADR_STATE) begin
      rdata = {rc_reg, 8'h00, pchg_reg, pfail_reg, txn_done_reg, batch_done_reg,
               txn_active_reg, paused_reg, ctl_reg.valve_open, authorized_reg};
    end else if (adr_i >= `TC_ADR_RSP && roff < `TC_RSP_BYTES) begin
      rdata = {16'h0000, resp_mem[roff[7:2]]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 4; i++) begin
        cmd_mem[i] <= '0;
      end
    end else if (acc & we_i & (adr_i < `TC_ADR_CMD_END)) begin
      if (sel_i[0]) begin
        cmd_mem[adr_i[3:2]][7:0] <= dat_i[7:0];
      end
      if (sel_i[1]) begin
        cmd_mem[adr_i[3:2]][15:8] <= dat_i[15:8];
      end
    end
  end

  // packet check; anything failing it is answered but changes nothing
  assign sub = cmd_mem[2];
  always_comb begin
    rc_w = `TC_RC_OK;
    if (cmd_mem[1] != `TC_ROUTER_CMD) begin
      rc_w = `TC_RC_BAD_ROUTER;
    end else if (cmd_mem[0] != `TC_LEN_CMD) begin
      rc_w = `TC_RC_BAD_LEN;
    end else if (sub < SUB_END_BATCH || sub > SUB_CLR_PROG) begin
      rc_w = `TC_RC_BAD_SUB;
    end
  end
  assign cmd_ok = (rc_w == `TC_RC_OK);
  assign do_eb = exec_go & cmd_ok & (sub == SUB_END_BATCH);
  assign do_et = exec_go & cmd_ok & (sub == SUB_END_TXN);
  assign do_start = exec_go & cmd_ok & (sub == SUB_START);
  assign do_stop = exec_go & cmd_ok & (sub == SUB_STOP);
  assign do_stat = exec_go & cmd_ok & (sub == SUB_READ_STAT);
  assign do_clr_both = exec_go & cmd_ok & (sub == SUB_CLR_BOTH);
  assign do_clr_batch = exec_go & cmd_ok & (sub == SUB_CLR_BATCH);
  assign do_clr_pf = exec_go & cmd_ok & (sub == SUB_CLR_PFAIL);
  assign do_clr_pg = exec_go & cmd_ok & (sub == SUB_CLR_PROG);

  assign start_evt = rise.start_key | do_start;
  assign halt = do_stop | do_eb | do_et | rise.batch_complete;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      authorized_reg <= 1'b0;
      txn_active_reg <= 1'b0;
    end else if (do_et) begin
      authorized_reg <= 1'b0;
      txn_active_reg <= 1'b0;
    end else begin
      authorized_reg <= authorized_reg | rise.authorize;
      txn_active_reg <= txn_active_reg | (start_evt & authorized_reg);
    end
  end

  // valve and pump follow the run state; a stop always wins over a start
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_reg <= '0;
      paused_reg <= 1'b0;
    end else begin
      ctl_reg.authorized <= authorized_reg & ~do_et;
      ctl_reg.discard_batch <= do_eb;
      ctl_reg.valve_close <= halt & ctl_reg.valve_open;
      if (halt) begin
        ctl_reg.valve_open <= 1'b0;
        ctl_reg.pump_run <= 1'b0;
        paused_reg <= do_stop & ctl_reg.valve_open;
      end else if (start_evt & authorized_reg & ~txn_done_reg) begin
        ctl_reg.valve_open <= 1'b1;
        ctl_reg.pump_run <= 1'b1;
        paused_reg <= 1'b0;
      end
    end
  end
  assign ctl_o = ctl_reg;

  // sticky flags: a hardware set in the same cycle as a clear is kept
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      batch_done_reg <= 1'b0;
      txn_done_reg <= 1'b0;
      pfail_reg <= 1'b0;
      pchg_reg <= 1'b0;
    end else begin
      batch_done_reg <= do_eb | do_et | rise.batch_complete |
                        (batch_done_reg & ~(do_clr_both | do_clr_batch));
      txn_done_reg <= do_et | (txn_done_reg & ~do_clr_both);
      pfail_reg <= rise.power_fail | (pfail_reg & ~do_clr_pf);
      pchg_reg <= rise.prog_changed | (pchg_reg & ~do_clr_pg);
    end
  end

  // flag words 4..23 in order; word 20 is carried separately
  assign flags_w = {dev_reg.txn_lock, dev_reg.storage_full, dev_reg.standby, 1'b0,
                    dev_reg.print_queued, pfail_reg, pchg_reg, dev_reg.prog_check,
                    dev_reg.prog_mode, dev_reg.alarm, dev_reg.proving, dev_reg.inj_auth,
                    dev_reg.flowing, dev_reg.valve_delay, dev_reg.start_stop_delay,
                    txn_done_reg, batch_done_reg, txn_active_reg, ctl_reg.valve_open,
                    authorized_reg};

  always_comb begin
    for (int i = 0; i < `TC_RSP_WORDS; i++) begin
      rsp_w[i] = '0;
    end
    rsp_w[2] = rc_w;
    rsp_w[3] = sub;
    if (do_stat) begin
      rsp_w[0] = `TC_LEN_STAT;
      rsp_w[1] = `TC_ROUTER_STAT;
      for (int i = `TC_STAT_FIRST; i <= `TC_STAT_LAST; i++) begin
        rsp_w[i] = {15'h0000, flags_w[i-`TC_STAT_FIRST]};
      end
      rsp_w[`TC_ARM_WORD] = {12'h000, dev_reg.arm_pos};
    end else begin
      rsp_w[0] = `TC_LEN_RSP;
      rsp_w[1] = `TC_ROUTER_RSP;
    end
  end

  // the answer is a snapshot taken on the execute edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rc_reg <= '0;
      for (int i = 0; i < `TC_RSP_WORDS; i++) begin
        resp_mem[i] <= '0;
      end
    end else if (exec_go) begin
      rc_reg <= rc_w;
      for (int i = 0; i < `TC_RSP_WORDS; i++) begin
        resp_mem[i] <= rsp_w[i];
      end
    end
  end

  property p_eb_done;
    @(posedge clk_i) disable iff (rst_i)
    do_eb |=> batch_done_reg && !ctl_reg.valve_open && ctl_reg.discard_batch;
  endproperty
  a_eb_done: assert property (p_eb_done) else $error("end batch not applied");

  property p_eb_close;
    @(posedge clk_i) disable iff (rst_i)
    do_eb |=> ctl_reg.valve_close == $past(ctl_reg.valve_open);
  endproperty
  a_eb_close: assert property (p_eb_close) else $error("valve close wrong");

  property p_et;
    @(posedge clk_i) disable iff (rst_i)
    do_et |=> !authorized_reg && txn_done_reg && !txn_active_reg ##1 !ctl_reg.authorized;
  endproperty
  a_et: assert property (p_et) else $error("end transaction not applied");

  property p_start;
    @(posedge clk_i) disable iff (rst_i)
    start_evt && !halt && authorized_reg && !txn_done_reg |=> ctl_reg.valve_open;
  endproperty
  a_start: assert property (p_start) else $error("start did not open valve");

  property p_stop;
    @(posedge clk_i) disable iff (rst_i)
    do_stop |=> !ctl_reg.valve_open && !ctl_reg.pump_run;
  endproperty
  a_stop: assert property (p_stop) else $error("stop left valve or pump on");

  property p_resume;
    @(posedge clk_i) disable iff (rst_i)
    $rose(ctl_reg.valve_open) |-> $past(start_evt);
  endproperty
  a_resume: assert property (p_resume) else $error("valve opened without start");

  property p_rsp6;
    @(posedge clk_i) disable iff (rst_i)
    exec_go && !do_stat |=> resp_mem[0] == `TC_LEN_RSP && resp_mem[1] == `TC_ROUTER_RSP
      && resp_mem[3] == $past(sub);
  endproperty
  a_rsp6: assert property (p_rsp6) else $error("short answer malformed");

  property p_stat;
    @(posedge clk_i) disable iff (rst_i)
    do_stat |=> resp_mem[0] == `TC_LEN_STAT && resp_mem[1] == `TC_ROUTER_STAT
      && (resp_mem[7] != 16'h0000) == $past(batch_done_reg)
      && (resp_mem[18] != 16'h0000) == $past(pfail_reg);
  endproperty
  a_stat: assert property (p_stat) else $error("status answer malformed");

  property p_clr_batch;
    @(posedge clk_i) disable iff (rst_i)
    do_clr_batch && !rise.batch_complete |=> !batch_done_reg
      && txn_done_reg == $past(txn_done_reg);
  endproperty
  a_clr_batch: assert property (p_clr_batch) else $error("batch clear wrong");

  property p_bad;
    @(posedge clk_i) disable iff (rst_i)
    exec_go && !cmd_ok && !rise.start_key && !rise.batch_complete |=>
      resp_mem[2] != `TC_RC_OK && $stable(ctl_reg.valve_open) && $stable(txn_done_reg);
  endproperty
  a_bad: assert property (p_bad) else $error("bad packet acted on");

  property p_sticky;
    @(posedge clk_i) disable iff (rst_i)
    pfail_reg && !do_clr_pf |=> pfail_reg;
  endproperty
  a_sticky: assert property (p_sticky) else $error("power fail flag lost");

  property p_clr_both;
    @(posedge clk_i) disable iff (rst_i)
    do_clr_both && !rise.batch_complete |=> !batch_done_reg && !txn_done_reg;
  endproperty
  a_clr_both: assert property (p_clr_both) else $error("flags not cleared");

  property p_clr_pf;
    @(posedge clk_i) disable iff (rst_i)
    do_clr_pf && !rise.power_fail |=> !pfail_reg;
  endproperty
  a_clr_pf: assert property (p_clr_pf) else $error("power fail not cleared");

  property p_clr_pg;
    @(posedge clk_i) disable iff (rst_i)
    do_clr_pg && !rise.prog_changed |=> !pchg_reg;
  endproperty
  a_clr_pg: assert property (p_clr_pg) else $error("program change not cleared");

  property p_pf_set;
    @(posedge clk_i) disable iff (rst_i)
    rise.power_fail |=> pfail_reg;
  endproperty
  a_pf_set: assert property (p_pf_set) else $error("power fail set lost");

  c_stop_resume: cover property (@(posedge clk_i) disable iff (rst_i)
    do_stop && ctl_reg.valve_open ##[1:50] do_start);
  c_stat: cover property (@(posedge clk_i) disable iff (rst_i) do_stat && pfail_reg);
  c_bad: cover property (@(posedge clk_i) disable iff (rst_i) exec_go && !cmd_ok);
  c_clr_race: cover property (@(posedge clk_i) disable iff (rst_i)
    do_clr_pf && rise.power_fail);

endmodule // transaction_control_service

//--- logic/tc_consts.svh
`ifndef TC_CONSTS_SVH
`define TC_CONSTS_SVH
`define TC_ROUTER_CMD 16'h0400
`define TC_ROUTER_RSP 16'h8400
`define TC_ROUTER_STAT 16'h8300
`define TC_LEN_CMD 16'h0004
`define TC_LEN_RSP 16'h0006
`define TC_LEN_STAT 16'h0026
`define TC_RC_OK 16'h0000
`define TC_RC_BAD_LEN 16'h0001
`define TC_RC_BAD_ROUTER 16'h0002
`define TC_RC_BAD_SUB 16'h0003
`define TC_ADR_CMD_END 12'h010
`define TC_ADR_EXEC 12'h040
`define TC_ADR_STATE 12'h044
`define TC_ADR_RSP 12'h100
`define TC_RSP_BYTES 12'h098
`define TC_RSP_WORDS 38
`define TC_STAT_FIRST 4
`define TC_STAT_LAST 23
`define TC_ARM_WORD 20
`endif

//--- logic/tc_pkg.sv
package tc_pkg;
  typedef enum logic [15:0] {
    SUB_END_BATCH = 16'h0004,
    SUB_END_TXN = 16'h0005,
    SUB_START = 16'h0006,
    SUB_STOP = 16'h0007,
    SUB_READ_STAT = 16'h0008,
    SUB_CLR_BOTH = 16'h0009,
    SUB_CLR_BATCH = 16'h000A,
    SUB_CLR_PFAIL = 16'h000B,
    SUB_CLR_PROG = 16'h000C
  } sub_e;

  // synchronised device-side status pins
  typedef struct packed {
    logic [3:0] arm_pos;
    logic txn_lock;
    logic storage_full;
    logic standby;
    logic print_queued;
    logic prog_check;
    logic prog_mode;
    logic proving;
    logic inj_auth;
    logic flowing;
    logic valve_delay;
    logic start_stop_delay;
    logic alarm;
    logic prog_changed;
    logic power_fail;
    logic batch_complete;
    logic authorize;
    logic start_key;
  } dev_status_s;

  typedef struct packed {
    logic valve_open;
    logic pump_run;
    logic authorized;
    logic valve_close;
    logic discard_batch;
  } dev_ctl_s;
endpackage

//--- dv/host_model.sv
`include "tc_consts.svh"

module host_model (
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [31:0] dat_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [11:0] adr_o,
  output logic [31:0] dat_o,
  output logic [3:0] sel_o,
  output logic hung_o
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 12'h000;
    dat_o = 32'h0000_0000;
    sel_o = 4'h3;
    hung_o = 1'b0;
  end

  // released lines flip to the inverse so a stale word is never mistaken for a live one
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    dat_o <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_i !== 1'b1 && n < 64);
    if (ack_i !== 1'b1) hung_o <= 1'b1;
    q = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    adr_o <= ~a;
    dat_o <= ~d;
  endtask

  task automatic cmd(input logic [15:0] cnt, input logic [15:0] rtr, input logic [15:0] sub);
    logic [31:0] q;
    xfer(1'b1, 12'h000, {16'h0000, cnt}, q);
    xfer(1'b1, 12'h004, {16'h0000, rtr}, q);
    xfer(1'b1, 12'h008, {16'h0000, sub}, q);
    xfer(1'b1, `TC_ADR_EXEC, 32'h0000_0001, q);
    // effects land on the ack edge of the execute write; two more edges follow
    repeat (2) @(posedge clk_i);
  endtask
endmodule // host_model

//--- dv/transaction_control_service_tb.sv
`include "tc_consts.svh"

module transaction_control_service_tb
  import tc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk_i;
  logic rst_i;
  logic cyc, stb, we, ack, hung;
  logic [11:0] adr;
  logic [31:0] wdat, rdat, q;
  logic [3:0] sel;
  logic [31:0] e;
  logic [11:0] p;
  dev_status_s dev;
  dev_ctl_s ctl;
  int failures = 0;
  int n_compared = 0;
  int n_close = 0;
  int m, md;
  int n_disc = 0;
  logic [63:0] w;
  int wl[12] = '{9, 10, 11, 12, 13, 14, 15, 16, 19, 21, 22, 23};
  // count, router, sub, return code
  logic [63:0] rows[12] = '{
    64'h0004_0400_0004_0000, 64'h0004_0400_0005_0000, 64'h0004_0400_0006_0000,
    64'h0004_0400_0007_0000, 64'h0004_0400_0008_0000, 64'h0004_0400_0009_0000,
    64'h0004_0400_000A_0000, 64'h0004_0400_000B_0000, 64'h0004_0400_000C_0000,
    64'h0006_0400_0004_0001, 64'h0004_0401_0006_0002, 64'h0004_0400_000D_0003};

  transaction_control_service u_transaction_control_service (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .dat_i(wdat), .sel_i(sel), .dat_o(rdat), .ack_o(ack), .dev_i(dev), .ctl_o(ctl));

  host_model u_host_model (
    .clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb), .we_o(we),
    .adr_o(adr), .dat_o(wdat), .sel_o(sel), .hung_o(hung));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    if (ctl.valve_close === 1'b1) n_close++;
    if (ctl.discard_batch === 1'b1) n_disc++;
  end

  task automatic complete_run();
    if (failures == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  always @(posedge hung) begin
    failures++;
    complete_run();
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [11:0] a);
    u_host_model.xfer(1'b0, a, 32'h0000_0000, q);
  endtask

  task automatic run(input logic [15:0] s);
    u_host_model.cmd(`TC_LEN_CMD, `TC_ROUTER_CMD, s);
  endtask

  task automatic state(input logic [31:0] mask, input logic [31:0] exp);
    rd(`TC_ADR_STATE);
    chk(q & mask, exp);
  endtask

  task automatic pins(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  initial begin
    rst_i = 1'b1;
    dev = '0;
    pins(16);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk({27'h0, ctl}, 32'h0000_0000);
    state(32'hFFFF_FFFF, 32'h0000_0000);
    for (int r = 0; r < 12; r++) begin
      u_host_model.cmd(rows[r][63:48], rows[r][47:32], rows[r][31:16]);
      e = (rows[r][15:0] == 16'h0000 && rows[r][31:16] == SUB_READ_STAT) ?
          {`TC_LEN_STAT, `TC_ROUTER_STAT} : {`TC_LEN_RSP, `TC_ROUTER_RSP};
      w = {e, rows[r][15:0], rows[r][31:16]};
      for (int i = 0; i < 4; i++) begin
        rd(`TC_ADR_RSP + 12'(4 * i));
        chk(q, {16'h0000, w[63 - 16 * i -: 16]});
      end
    end
    for (int k = 0; k < 2; k++) begin
      p = k ? 12'h5A5 : 12'hA5A;
      {dev.txn_lock, dev.storage_full, dev.standby, dev.print_queued, dev.prog_check,
       dev.prog_mode, dev.alarm, dev.proving, dev.inj_auth, dev.flowing, dev.valve_delay,
       dev.start_stop_delay} <= p;
      dev.arm_pos <= k ? 4'h5 : 4'hA;
      pins(6);
      run(SUB_READ_STAT);
      for (int i = 0; i < 12; i++) begin
        rd(`TC_ADR_RSP + 12'(4 * wl[i]));
        chk({31'h0, |q}, {31'h0, p[i]});
      end
      rd(`TC_ADR_RSP + 12'(4 * `TC_ARM_WORD));
      chk(q, k ? 32'h0000_0005 : 32'h0000_000A);
    end
    dev <= '0;
    pins(6);
    dev.authorize <= 1'b1;
    pins(6);
    state(32'h0000_0001, 32'h0000_0001);
    run(SUB_START);
    chk({30'h0, ctl.valve_open, ctl.pump_run}, 32'h0000_0003);
    run(SUB_STOP);
    chk({30'h0, ctl.valve_open, ctl.pump_run}, 32'h0000_0000);
    state(32'h0000_0004, 32'h0000_0004);
    // a press of the local start key resumes the batch stopped by the remote stop
    dev.start_key <= 1'b1;
    pins(6);
    dev.start_key <= 1'b0;
    pins(4);
    chk({30'h0, ctl.valve_open, ctl.pump_run}, 32'h0000_0003);
    run(SUB_STOP);
    run(SUB_START);
    chk({30'h0, ctl.valve_open, ctl.pump_run}, 32'h0000_0003);
    m = n_close;
    md = n_disc;
    run(SUB_END_BATCH);
    chk(32'(n_close), 32'(m + 1));
    chk(32'(n_disc), 32'(md + 1));
    chk({30'h0, ctl.valve_open, ctl.pump_run}, 32'h0000_0000);
    run(SUB_END_BATCH);
    chk(32'(n_close), 32'(m + 1));
    chk(32'(n_disc), 32'(md + 2));
    run(SUB_READ_STAT);
    rd(`TC_ADR_RSP + 12'h01C);
    chk({31'h0, |q}, 32'h0000_0001);
    state(32'h0000_0010, 32'h0000_0010);
    run(SUB_END_TXN);
    state(32'h0000_0031, 32'h0000_0030);
    chk({31'h0, ctl.authorized}, 32'h0000_0000);
    run(SUB_CLR_BATCH);
    state(32'h0000_0030, 32'h0000_0020);
    run(SUB_CLR_BOTH);
    state(32'h0000_0030, 32'h0000_0000);
    dev.power_fail <= 1'b1;
    dev.prog_changed <= 1'b1;
    pins(6);
    dev.power_fail <= 1'b0;
    dev.prog_changed <= 1'b0;
    pins(6);
    state(32'h0000_00C0, 32'h0000_00C0);
    u_host_model.cmd(16'h0005, `TC_ROUTER_CMD, SUB_CLR_PFAIL);
    state(32'hFFFF_00C0, 32'h0001_00C0);
    run(SUB_CLR_PFAIL);
    state(32'h0000_00C0, 32'h0000_0080);
    run(SUB_CLR_PROG);
    state(32'h0000_00C0, 32'h0000_0000);
    complete_run();
  end
endmodule // transaction_control_service_tb
